//--- sas_sequencer.v
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "sas_map.vh"
// Operation
// - select low enables the converter; select high disables and powers down.
// - bits launch on shift clock falling edges and are captured on rising edges.
// - single-input mode starts at select fall; output enabled at second pulse.
// - single-input mode drives one null bit, then the result msb first.
// - single-input mode sends msb first, then the same result lsb first.
// - select high returns the serial logic to idle.
// - two-channel mode skips zeros; first one sampled is the start bit.
// - three config bits follow the start bit: mode, polarity, format.
// - two-channel mode samples serial_in on shift clock rising edges.
// - after the config word serial_in is ignored until the next frame.
// - mux mapping: 10 a-gnd, 11 b-gnd, 00 a-b, 01 b-a.
// - two-channel mode sends one null bit after config, then the result.
// - msb-only format sends msb first then zeros while clock runs.
// - otherwise the msb-first result is followed by lsb-first result.
// - result is twelve bits by successive approximation on shift clock.
// - shared data wire; device drives only after host releases it.
// - shared wire driven low on fourth falling edge after start bit.
// - sample input for one and a half shift clock cycles.
// - bias and comparator power down after conversion; shifting continues.
module sas_sequencer (
  input wire core_clk,
  input wire sys_rst,
  input wire chip_select_shutdown_n,
  input wire shift_clk,
  input wire serial_in,
  input wire [`SAS_RES_W-1:0] analog_in_a,
  input wire [`SAS_RES_W-1:0] analog_in_b,
  output wire serial_out,
  output wire serial_out_oe,
  output wire single_or_diff_sel,
  output wire channel_polarity_sel,
  output wire sample_tracking,
  output wire converter_powered,
  input wire [`SAS_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest
);
  // ---------------------------------------------------------------
  // states and declarations
  // ---------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_HUNT = 2'b01;
  localparam [1:0] ST_CFG = 2'b10;
  localparam [1:0] ST_XFER = 2'b11;

  reg [1:0] state_r;
  reg [4:0] fall_cnt_r;
  reg [4:0] cfg_cnt_r;
  reg dual_r;
  reg msb_only_format_r;
  reg sgl_r;
  reg pol_r;
  reg out_r;
  reg oe_r;
  reg track_r;
  reg power_r;
  reg sar_load_r;
  reg [`SAS_RES_W-1:0] last_res_r;
  reg [2:0] last_cfg_r;
  reg last_dual_r;
  reg res_new_r;
  reg ctrl_dual_r;
  reg wait_r;
  reg [31:0] rdata_r;
  reg [31:0] rd_mux;
  reg [2*`SAS_RES_W-1:0] ana_meta_r;
  reg [2*`SAS_RES_W-1:0] ana_sync_r;

  wire cs_lvl;
  wire cs_fall;
  wire clk_rise;
  wire clk_fall;
  wire din_lvl;
  wire sar_bit;
  wire [`SAS_RES_W-1:0] sar_res;
  wire [`SAS_RES_W-1:0] mux_val;
  wire [4:0] null_at;
  wire [4:0] fall_cnt_nxt;
  wire [4:0] k_nxt;
  wire [4:0] msb_idx;
  wire [4:0] lsb_idx;
  wire in_msb;
  wire in_lsb;
  wire at_null;
  wire sar_step;
  wire rd_clr;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // counter that parks at its top value, so long trailing clocks
  // after the frame keep sending zeros instead of wrapping round
  function [4:0] sat_inc;
    input [4:0] v;
    begin
      sat_inc = (v == `SAS_CNT_MAX) ? v : v + `SAS_CNT_ONE;
    end
  endfunction

  // unipolar difference, negative inputs clip at zero code
  function [`SAS_RES_W-1:0] pos_diff;
    input [`SAS_RES_W-1:0] p;
    input [`SAS_RES_W-1:0] n;
    begin
      pos_diff = (p > n) ? p - n : `SAS_RES_ZERO;
    end
  endfunction

  // input multiplexer mapping
  function [`SAS_RES_W-1:0] mux_pick;
    input sgl;
    input pol;
    input [`SAS_RES_W-1:0] a;
    input [`SAS_RES_W-1:0] b;
    begin
      if (sgl)
        mux_pick = pol ? b : a;
      else
        mux_pick = pol ? pos_diff(b, a) : pos_diff(a, b);
    end
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  sas_pin_sync #(.RST_VAL(1'b1)) u_cs_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_async(chip_select_shutdown_n),
    .level(cs_lvl),
    .rise(),
    .fall(cs_fall)
  );

  sas_pin_sync #(.RST_VAL(1'b0)) u_clk_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_async(shift_clk),
    .level(),
    .rise(clk_rise),
    .fall(clk_fall)
  );

  sas_pin_sync #(.RST_VAL(1'b0)) u_din_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_async(serial_in),
    .level(din_lvl),
    .rise(),
    .fall()
  );

  // analog codes only matter at the hold instant; the bench keeps
  // them steady around it, so a plain two-stage copy is enough
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ana_meta_r <= {`SAS_RES_ZERO, `SAS_RES_ZERO};
      ana_sync_r <= {`SAS_RES_ZERO, `SAS_RES_ZERO};
    end
    else
    begin
      ana_meta_r <= {analog_in_b, analog_in_a};
      ana_sync_r <= ana_meta_r;
    end
  end

  assign mux_val = mux_pick(sgl_r, pol_r, ana_sync_r[`SAS_RES_W-1:0],
    ana_sync_r[2*`SAS_RES_W-1:`SAS_RES_W]);

  // ---------------------------------------------------------------
  // bit position decode for the output phase
  // ---------------------------------------------------------------
  assign null_at = dual_r ? `SAS_NULL_DUAL : `SAS_NULL_SINGLE;
  assign fall_cnt_nxt = sat_inc(fall_cnt_r);
  assign k_nxt = fall_cnt_nxt - null_at;
  assign at_null = (fall_cnt_nxt == null_at);
  assign in_msb = (k_nxt >= `SAS_CNT_ONE) && (k_nxt <= `SAS_MSB_LAST);
  assign in_lsb = (k_nxt > `SAS_MSB_LAST) && (k_nxt <= `SAS_LSB_LAST);
  assign msb_idx = `SAS_MSB_LAST - k_nxt;
  assign lsb_idx = k_nxt - `SAS_MSB_LAST;
  assign sar_step = (state_r == ST_XFER) && clk_fall && in_msb;

  sas_sar u_sar (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(sar_load_r),
    .sample_in(mux_val),
    .step(sar_step),
    .bit_idx(msb_idx[3:0]),
    .bit_now(sar_bit),
    .result(sar_res)
  );

  assign rd_clr = wait_r && avs_read && !avs_write &&
    (avs_address == `SAS_OFF_RESULT);

  // ---------------------------------------------------------------
  // link sequencer
  // ---------------------------------------------------------------
  // one process owns the frame; select high overrides everything
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= ST_IDLE;
      fall_cnt_r <= `SAS_CNT_ZERO;
      cfg_cnt_r <= `SAS_CNT_ZERO;
      dual_r <= `SAS_CTRL_DUAL_RST;
      msb_only_format_r <= 1'b0;
      sgl_r <= 1'b0;
      pol_r <= 1'b0;
      out_r <= 1'b0;
      oe_r <= 1'b0;
      track_r <= 1'b0;
      power_r <= 1'b0;
      sar_load_r <= 1'b0;
      last_res_r <= `SAS_RES_ZERO;
      last_cfg_r <= 3'h0;
      last_dual_r <= 1'b0;
      res_new_r <= 1'b0;
    end
    else
    begin
      sar_load_r <= 1'b0;
      if (rd_clr)
        res_new_r <= 1'b0;
      if (cs_lvl)
      begin
        // deselect: release the wire, power down, back to idle
        state_r <= ST_IDLE;
        oe_r <= 1'b0;
        out_r <= 1'b0;
        track_r <= 1'b0;
        power_r <= 1'b0;
        fall_cnt_r <= `SAS_CNT_ZERO;
        cfg_cnt_r <= `SAS_CNT_ZERO;
      end
      else
      begin
        case (state_r)
          ST_IDLE:
          begin
            if (cs_fall)
            begin
              // mode is taken once per frame so a bus write cannot
              // disturb a frame in flight
              dual_r <= ctrl_dual_r;
              fall_cnt_r <= `SAS_CNT_ZERO;
              if (ctrl_dual_r)
                state_r <= ST_HUNT;
              else
              begin
                // single-input: fixed a-b, both formats, no din
                sgl_r <= 1'b0;
                pol_r <= 1'b0;
                msb_only_format_r <= 1'b0;
                power_r <= 1'b1;
                state_r <= ST_XFER;
              end
            end
          end
          ST_HUNT:
          begin
            if (clk_rise && din_lvl)
            begin
              state_r <= ST_CFG;
              cfg_cnt_r <= `SAS_CNT_ZERO;
              fall_cnt_r <= `SAS_CNT_ZERO;
            end
          end
          ST_CFG:
          begin
            if (clk_fall)
              fall_cnt_r <= fall_cnt_nxt;
            if (clk_rise)
            begin
              cfg_cnt_r <= cfg_cnt_r + `SAS_CNT_ONE;
              if (cfg_cnt_r == `SAS_CFG_SGL_IDX)
                sgl_r <= din_lvl;
              if (cfg_cnt_r == `SAS_CFG_POL_IDX)
              begin
                // mux known: bias on and start tracking the input
                pol_r <= din_lvl;
                power_r <= 1'b1;
                track_r <= 1'b1;
              end
              if (cfg_cnt_r == `SAS_CFG_LAST)
              begin
                msb_only_format_r <= din_lvl;
                state_r <= ST_XFER;
              end
            end
          end
          ST_XFER:
          begin
            // serial_in is not looked at here at all
            if (clk_rise && !dual_r && fall_cnt_r == `SAS_CNT_ZERO)
              track_r <= 1'b1;
            if (clk_fall)
            begin
              fall_cnt_r <= fall_cnt_nxt;
              if (at_null)
              begin
                // hold after 1.5 clocks of tracking; drive the null
                track_r <= 1'b0;
                sar_load_r <= 1'b1;
                oe_r <= 1'b1;
                out_r <= 1'b0;
              end
              else if (in_msb)
              begin
                out_r <= sar_bit;
                if (k_nxt == `SAS_MSB_LAST)
                begin
                  // conversion over: bias and comparator off
                  power_r <= 1'b0;
                  last_res_r <= sar_res | (sar_bit ? `SAS_RES_ONE :
                    `SAS_RES_ZERO);
                  last_cfg_r <= {sgl_r, pol_r, msb_only_format_r};
                  last_dual_r <= dual_r;
                  res_new_r <= 1'b1;
                end
              end
              else if (in_lsb && !msb_only_format_r)
                out_r <= last_res_r[lsb_idx[3:0]];
              else
                out_r <= 1'b0;
            end
          end
          default:
          begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // avalon-mm slave
  // ---------------------------------------------------------------
  // read mux; unmapped addresses read zero
  always @*
  begin
    rd_mux = `SAS_DATA_ZERO;
    case (avs_address)
      `SAS_OFF_CTRL:
        rd_mux[`SAS_CTRL_DUAL] = ctrl_dual_r;
      `SAS_OFF_STATUS:
      begin
        rd_mux[`SAS_ST_FRAME] = ~cs_lvl;
        rd_mux[`SAS_ST_POWER] = power_r;
        rd_mux[`SAS_ST_TRACK] = track_r;
        rd_mux[`SAS_ST_OE] = oe_r;
        rd_mux[`SAS_ST_STATE_HI:`SAS_ST_STATE_LO] = state_r;
        rd_mux[`SAS_ST_FALL_HI:`SAS_ST_FALL_LO] = fall_cnt_r;
      end
      `SAS_OFF_RESULT:
      begin
        rd_mux[`SAS_RES_HI:`SAS_RES_LO] = last_res_r;
        rd_mux[`SAS_RES_NEW] = res_new_r;
      end
      `SAS_OFF_CONFIG:
      begin
        rd_mux[`SAS_CFG_SGL] = last_cfg_r[2];
        rd_mux[`SAS_CFG_POL] = last_cfg_r[1];
        rd_mux[`SAS_CFG_MSB_ONLY_FORMAT] = last_cfg_r[0];
        rd_mux[`SAS_CFG_DUAL] = last_dual_r;
      end
      default:
        rd_mux = `SAS_DATA_ZERO;
    endcase
  end

  // fixed one-cycle answer: accept, then drop waitrequest for one
  // cycle; the write lands on that completion edge
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wait_r <= 1'b1;
      rdata_r <= `SAS_DATA_ZERO;
      ctrl_dual_r <= `SAS_CTRL_DUAL_RST;
    end
    else if (wait_r)
    begin
      if (avs_read || avs_write)
      begin
        wait_r <= 1'b0;
        rdata_r <= avs_read ? rd_mux : `SAS_DATA_ZERO;
      end
    end
    else
    begin
      wait_r <= 1'b1;
      if (avs_write && avs_byteenable[0] &&
          avs_address == `SAS_OFF_CTRL)
        ctrl_dual_r <= avs_writedata[`SAS_CTRL_DUAL];
    end
  end

  // ---------------------------------------------------------------
  // outputs, all registered
  // ---------------------------------------------------------------
  assign serial_out = out_r;
  assign serial_out_oe = oe_r;
  assign single_or_diff_sel = sgl_r;
  assign channel_polarity_sel = pol_r;
  assign sample_tracking = track_r;
  assign converter_powered = power_r;
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
endmodule

//--- sas_map.vh
`ifndef SAS_MAP_VH
`define SAS_MAP_VH

// ---------------------------------------------------------------
// register map (byte addresses, one aligned word each)
// ---------------------------------------------------------------
`define SAS_ADDR_W 5
`define SAS_OFF_CTRL 5'h00
`define SAS_OFF_STATUS 5'h04
`define SAS_OFF_RESULT 5'h08
`define SAS_OFF_CONFIG 5'h0c
`define SAS_DATA_ZERO 32'h00000000

// ctrl fields
`define SAS_CTRL_DUAL 0
`define SAS_CTRL_DUAL_RST 1'b1

// status fields
`define SAS_ST_FRAME 0
`define SAS_ST_POWER 1
`define SAS_ST_TRACK 2
`define SAS_ST_OE 3
`define SAS_ST_STATE_LO 4
`define SAS_ST_STATE_HI 5
`define SAS_ST_FALL_LO 8
`define SAS_ST_FALL_HI 12

// result fields
`define SAS_RES_LO 0
`define SAS_RES_HI 11
`define SAS_RES_NEW 16

// config fields
`define SAS_CFG_MSB_ONLY_FORMAT 0
`define SAS_CFG_POL 1
`define SAS_CFG_SGL 2
`define SAS_CFG_DUAL 3

// ---------------------------------------------------------------
// conversion and link sequencing
// ---------------------------------------------------------------
`define SAS_RES_W 12
`define SAS_RES_ZERO 12'h000
`define SAS_RES_ONE 12'h001
`define SAS_CNT_ZERO 5'h00
`define SAS_CNT_ONE 5'h01
`define SAS_CNT_MAX 5'h1f
`define SAS_NULL_DUAL 5'h04
`define SAS_NULL_SINGLE 5'h02
`define SAS_CFG_SGL_IDX 5'h00
`define SAS_CFG_POL_IDX 5'h01
`define SAS_CFG_LAST 5'h02
`define SAS_MSB_LAST 5'h0c
`define SAS_LSB_LAST 5'h17

`endif

//--- sas_pin_sync.v
`timescale 1ns/1ps
// ---------------------------------------------------------------
// two-stage synchroniser with edge detect on the settled copy
// ---------------------------------------------------------------
module sas_pin_sync #(
  parameter [0:0] RST_VAL = 1'b0
) (
  input wire core_clk,
  input wire sys_rst,
  input wire pin_async,
  output wire level,
  output wire rise,
  output wire fall
);
  reg meta_r;
  reg sync_r;
  reg last_r;

  // only sync_r reads meta_r; edges come from sync_r against last_r
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
      last_r <= RST_VAL;
    end
    else
    begin
      meta_r <= pin_async;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise = sync_r & ~last_r;
  assign fall = ~sync_r & last_r;
endmodule

//--- sas_sar.v
`timescale 1ns/1ps
`include "sas_map.vh"
// ---------------------------------------------------------------
// successive approximation register against a held sample
// ---------------------------------------------------------------
module sas_sar (
  input wire core_clk,
  input wire sys_rst,
  input wire load,
  input wire [`SAS_RES_W-1:0] sample_in,
  input wire step,
  input wire [3:0] bit_idx,
  output wire bit_now,
  output wire [`SAS_RES_W-1:0] result
);
  reg [`SAS_RES_W-1:0] held_r;
  reg [`SAS_RES_W-1:0] result_r;
  wire [`SAS_RES_W-1:0] trial;

  // comparator: keep the trial bit if the sample reaches it
  assign trial = result_r | (`SAS_RES_ONE << bit_idx);
  assign bit_now = (held_r >= trial);

  // load freezes the sample; each step decides one bit, msb down
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      held_r <= `SAS_RES_ZERO;
      result_r <= `SAS_RES_ZERO;
    end
    else if (load)
    begin
      held_r <= sample_in;
      result_r <= `SAS_RES_ZERO;
    end
    else if (step)
    begin
      result_r <= bit_now ? trial : result_r;
    end
  end

  assign result = result_r;
endmodule

//--- sas_seq_chk_sva.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// link and bus timing checks at the sequencer ports
// ---------------------------------------------------------------
module sas_seq_chk (
  input wire core_clk,
  input wire sys_rst,
  input wire chip_select_shutdown_n,
  input wire shift_clk,
  input wire serial_out,
  input wire serial_out_oe,
  input wire sample_tracking,
  input wire converter_powered,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest
);
  reg [5:0] trk_len_r;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // cycles the tracking window has been open; cleared when it closes
  always @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
      trk_len_r <= 6'h00;
    else if (sample_tracking)
      trk_len_r <= trk_len_r + 6'h01;
    else
      trk_len_r <= 6'h00;
  // cs high lets 2ff sync settle, then everything must be off
  a_idle_quiet: assert property (chip_select_shutdown_n [*5] |->
    !serial_out_oe && !converter_powered && !sample_tracking)
    else $error("link active while deselected");
  a_undriven_low: assert property (!serial_out_oe |-> !serial_out)
    else $error("data out high while not driven");
  a_out_hold_hi: assert property ((shift_clk &&
    !chip_select_shutdown_n) [*4] |->
    $stable(serial_out) && $stable(serial_out_oe))
    else $error("data out moved while shift clock high");
  a_null_lead: assert property ($rose(serial_out_oe) |->
    !serial_out)
    else $error("first driven bit is not the null bit");
  a_enable_ends_track: assert property ($rose(serial_out_oe) |->
    $past(sample_tracking) || $past(sample_tracking, 2))
    else $error("output enabled outside the end of sampling");
  a_track_span: assert property ($fell(sample_tracking) &&
    !chip_select_shutdown_n |-> trk_len_r == 6'h18)
    else $error("sample window not one and a half clocks");
  a_off_after_b0: assert property ($fell(converter_powered) &&
    !chip_select_shutdown_n |-> serial_out_oe)
    else $error("power dropped without shifting going on");
  a_oe_drop_cause: assert property ($fell(serial_out_oe) |->
    $past(chip_select_shutdown_n, 2) || $past(chip_select_shutdown_n, 3)
    || $past(chip_select_shutdown_n, 4))
    else $error("output released while still selected");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  a_bus_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  cover property ($rose(serial_out_oe));
  cover property ($fell(converter_powered) && !chip_select_shutdown_n);
  cover property ($fell(sample_tracking) && !chip_select_shutdown_n);
  cover property (avs_read && !avs_waitrequest);
endmodule

bind sas_sequencer sas_seq_chk i_chk (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .chip_select_shutdown_n(chip_select_shutdown_n),
  .shift_clk(shift_clk),
  .serial_out(serial_out),
  .serial_out_oe(serial_out_oe),
  .sample_tracking(sample_tracking),
  .converter_powered(converter_powered),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest)
);

//--- sas_host_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// host on the far side: select, shift clock and data in
// ---------------------------------------------------------------
module sas_host_model (
  input wire core_clk,
  input wire dout,
  input wire dout_oe,
  output reg cs_n,
  output reg sclk,
  output reg din
);
  reg [39:0] cap;
  reg [39:0] capoe;
  // idle: deselected, clock parked low
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
    cap = 40'h0;
    capoe = 40'h0;
  end
  // frame of n pulses at 160 ns; first len pulses carry word msb first;
  // the clock stands still outside frames
  task frame(input [4:0] word, input integer len, input integer n);
    integer i;
    begin
      @(posedge core_clk);
      cs_n <= 1'b0;
      for (i = 0; i < n; i = i + 1)
      begin
        // launch with the falling edge
        if (i < len)
          din <= word[len-1-i];
        else
          din <= ~din; // released early, keeps moving
        repeat (8) @(posedge core_clk);
        sclk <= 1'b1;
        cap[i] <= dout;
        capoe[i] <= dout_oe;
        repeat (8) @(posedge core_clk);
        sclk <= 1'b0;
      end
      cs_n <= 1'b1;
      din <= 1'b0;
      repeat (16) @(posedge core_clk);
    end
  endtask
endmodule

//--- sas_testbench.sv
`timescale 1ns/1ps
`include "sas_map.vh"
module testbench;
  reg core_clk;
  reg sys_rst;
  reg [11:0] ain_a;
  reg [11:0] ain_b;
  reg [4:0] avs_address;
  reg avs_read;
  reg avs_write;
  reg [31:0] avs_writedata;
  wire cs_n;
  wire sclk;
  wire din;
  wire dout;
  wire dout_oe;
  wire sel_sgl;
  wire sel_pol;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  integer fail_count;
  integer checks_done;
  integer m;
  reg [31:0] rd;
  reg sg;
  reg pl;
  reg mf;
  reg [11:0] va;
  reg [11:0] vb;
  reg [11:0] res;

  sas_sequencer i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .chip_select_shutdown_n(cs_n), .shift_clk(sclk), .serial_in(din),
    .analog_in_a(ain_a), .analog_in_b(ain_b), .serial_out(dout),
    .serial_out_oe(dout_oe), .single_or_diff_sel(sel_sgl),
    .channel_polarity_sel(sel_pol), .sample_tracking(), .converter_powered(),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  sas_host_model i_host (.core_clk(core_clk), .dout(dout),
    .dout_oe(dout_oe), .cs_n(cs_n), .sclk(sclk), .din(din));

  // free-running 100 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
        fail_count = fail_count + 1;
        $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // one avalon transfer; held until waitrequest is sampled low
  task bus(input [4:0] a, input wr, input [31:0] d);
    begin
      @(posedge core_clk);
      avs_address <= a;
      avs_read <= ~wr;
      avs_write <= wr;
      avs_writedata <= d;
      // no cycle count assumed; a hang is left to the watchdog
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0)
        @(posedge core_clk);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask

  // expected bit at rise i: null at p, msb first, then lsb tail or zeros
  function [31:0] eb(input [11:0] r, input integer p, input m1,
    input integer i);
    begin
      if (i <= p || i > p + 23)
        eb = 32'h0;
      else if (i <= p + 12)
        eb = {31'h0, r[p+12-i]};
      else
        eb = m1 ? 32'h0 : {31'h0, r[i-p-12]};
    end
  endfunction

  task check_frame(input [11:0] r, input integer p, input m1,
    input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1)
      begin
        chk({31'h0, i_host.cap[i]}, eb(r, p, m1, i));
        chk({31'h0, i_host.capoe[i]}, {31'h0, i >= p});
      end
    end
  endtask

  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  // watchdog: the whole sequence needs about 3000 cycles
  initial
  begin
    #200000;
    fail_count = fail_count + 1;
    end_of_test;
  end

  // main sequence
  initial
  begin
    fail_count = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    ain_a = 12'h000;
    ain_b = 12'h000;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    bus(`SAS_OFF_CTRL, 1'b0, 32'h0);
    chk(rd, 32'h1);
    bus(5'h14, 1'b1, 32'hffffffff);
    bus(5'h14, 1'b0, 32'h0);
    chk(rd, 32'h0);
    bus(`SAS_OFF_RESULT, 1'b1, 32'hffffffff);
    bus(`SAS_OFF_RESULT, 1'b0, 32'h0);
    chk(rd, 32'h0);
    $display("register test done");
    // abort in mid conversion, then the next frames must run clean
    i_host.frame(5'h0d, 5, 10);
    bus(`SAS_OFF_STATUS, 1'b0, 32'h0);
    chk(rd & 32'h3f, 32'h0);
    $display("abort test done");
    for (m = 0; m < 4; m = m + 1)
    begin
      sg = m[1];
      pl = m[0];
      mf = m[1] ^ m[0];
      va = (m == 1) ? 12'h3a6 : 12'h9c5;
      vb = (m == 1) ? 12'h9c5 : 12'h3a6;
      ain_a <= va;
      ain_b <= vb;
      res = sg ? (pl ? vb : va) : (pl ? vb - va : va - vb);
      i_host.frame({1'b0, 1'b1, sg, pl, mf}, 5, 34);
      check_frame(res, 5, mf, 34);
      chk({30'h0, sel_sgl, sel_pol}, {30'h0, sg, pl});
      bus(`SAS_OFF_CONFIG, 1'b0, 32'h0);
      chk(rd, {28'h0, 1'b1, sg, pl, mf});
      bus(`SAS_OFF_RESULT, 1'b0, 32'h0);
      chk(rd, {15'h0, 1'b1, 4'h0, res});
      bus(`SAS_OFF_RESULT, 1'b0, 32'h0);
      chk(rd, {20'h0, res});
      $display("two-channel test %0d done", m);
    end
    bus(`SAS_OFF_CTRL, 1'b1, 32'h0);
    ain_a <= 12'h7e1;
    ain_b <= 12'h12c;
    i_host.frame(5'h00, 0, 30);
    check_frame(12'h6b5, 2, 1'b0, 30);
    chk({30'h0, sel_sgl, sel_pol}, 32'h0);
    bus(`SAS_OFF_CONFIG, 1'b0, 32'h0);
    chk(rd, 32'h0);
    bus(`SAS_OFF_RESULT, 1'b0, 32'h0);
    chk(rd, {15'h0, 1'b1, 4'h0, 12'h6b5});
    $display("single-input test done");
    end_of_test;
  end
endmodule
